/* rtl/i2c_addr_pkg.sv */
// Purpose: shared constants for the i2c slave address control block
// Assumes: 32-bit axi4-lite register bus, byte-wide registers in the low bits, except the 16-bit match info
// Notes: byte address of every register is four times its index
package i2c_addr_pkg;

  localparam int unsigned AXI_ADDR_W = 8;

  // register indices and byte addresses
  localparam logic [7:0] IDX_PRIMARY = 8'h02;
  localparam logic [7:0] IDX_CTRL2 = 8'h05;
  localparam logic [7:0] IDX_FILTER = 8'h06;
  localparam logic [7:0] IDX_RANGE = 8'h07;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h08;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h09;
  localparam logic [7:0] IDX_MATCH_INFO = 8'h0A;
  localparam logic [7:0] ADR_PRIMARY = IDX_PRIMARY << 2;
  localparam logic [7:0] ADR_CTRL2 = IDX_CTRL2 << 2;
  localparam logic [7:0] ADR_FILTER = IDX_FILTER << 2;
  localparam logic [7:0] ADR_RANGE = IDX_RANGE << 2;
  localparam logic [7:0] ADR_IRQ_STATUS = IDX_IRQ_STATUS << 2;
  localparam logic [7:0] ADR_IRQ_MASK = IDX_IRQ_MASK << 2;
  localparam logic [7:0] ADR_MATCH_INFO = IDX_MATCH_INFO << 2;

  // slave_address_control_two fields
  localparam int unsigned C2_GEN_CALL = 7;
  localparam int unsigned C2_TEN_BIT = 6;
  localparam int unsigned C2_RATE_IND = 4;
  localparam int unsigned C2_RANGE_EN = 3;
  localparam int unsigned C2_AD_LSB = 0;
  localparam logic [7:0] C2_WRITE_MASK = 8'hDF;

  // input_filter_and_bus_flags fields
  localparam int unsigned FL_HOLDOFF = 7;
  localparam int unsigned FL_STOP_SEEN = 6;
  localparam int unsigned FL_SS_IRQ_EN = 5;
  localparam int unsigned FL_START_SEEN = 4;
  localparam logic [7:0] FL_WRITE_MASK = 8'hAF;

  // interrupt status and mask layout
  localparam int unsigned IRQ_PEND = 0;

  // match info layout
  localparam int unsigned MI_GC = 12;
  localparam int unsigned MI_RANGE = 13;
  localparam int unsigned MI_TEN = 14;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [4:0] TEN_BIT_HEADER = 5'h1E;
  localparam logic [6:0] GENERAL_CALL = 7'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,
    ST_RECV = 5'h02,
    ST_ACK = 5'h04,
    ST_BUSY = 5'h08,
    ST_IGNORE = 5'h10
  } link_state_e;

endpackage

/* rtl/match_if.sv */
// Purpose: carries address settings to the matcher and its verdicts back
// Assumes: purely combinational traffic on one clock
// Notes: none
`timescale 1ns/10ps
interface match_if;
  logic gc_enable;
  logic ten_bit_mode;
  logic range_enable;
  logic [2:0] ad_upper;
  logic [6:0] primary;
  logic [6:0] range_limit;
  logic [7:0] rx_byte;
  logic hit_primary;
  logic hit_range;
  logic hit_gc;
  logic hit_hdr10;
  logic hit_low10;

  modport req
  (
    output gc_enable, ten_bit_mode, range_enable, ad_upper, primary, range_limit, rx_byte,
    input hit_primary, hit_range, hit_gc, hit_hdr10, hit_low10
  );
  modport mat
  (
    input gc_enable, ten_bit_mode, range_enable, ad_upper, primary, range_limit, rx_byte,
    output hit_primary, hit_range, hit_gc, hit_hdr10, hit_low10
  );
endinterface

/* rtl/addr_matcher.sv */
// Purpose: compares a received address byte against the programmed slave addresses
// Assumes: settings are stable while a byte is judged
// Notes: combinational only
`timescale 1ns/10ps
module addr_matcher
(
  match_if.mat m
);

  logic [9:0] target10;
  logic [6:0] rx7;

  assign rx7 = m.rx_byte[7:1];
  // ten-bit address is the upper field above the low primary bits
  assign target10 = {m.ad_upper, m.primary};
  assign m.hit_primary = !m.ten_bit_mode && (rx7 == m.primary);
  // range is exclusive of the primary and inclusive of the limit
  assign m.hit_range = !m.ten_bit_mode && m.range_enable && (rx7 > m.primary)
    && (rx7 <= m.range_limit);
  assign m.hit_gc = m.gc_enable && (rx7 == i2c_addr_pkg::GENERAL_CALL);
  assign m.hit_hdr10 = m.ten_bit_mode && (m.rx_byte[7:3] == i2c_addr_pkg::TEN_BIT_HEADER)
    && (m.rx_byte[2:1] == target10[9:8]);
  assign m.hit_low10 = m.ten_bit_mode && (m.rx_byte == target10[7:0]);

endmodule

/* rtl/i2c_slave_address_control.sv */
// Purpose: i2c slave address recognition with axi4-lite configuration registers
// Assumes: scl and sda arrive asynchronously and are sampled on aclk
// Notes: data bytes after the address are not handled; the slave at most stretches scl until software clears the pending flag
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module i2c_slave_address_control
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic irq
);

  i2c_addr_pkg::link_state_e state_ff;
  logic [2:0] scl_sync_ff;
  logic [2:0] sda_sync_ff;
  logic scl_lvl_ff;
  logic sda_lvl_ff;
  logic nxt_scl;
  logic nxt_sda;
  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;
  logic [7:0] primary_ff;
  logic [7:0] range_ff;
  logic [7:0] ctrl2_ff;
  logic [7:0] filter_ff;
  logic stop_seen_ff;
  logic start_seen_ff;
  logic pend_ff;
  logic mask_ff;
  logic irq_ff;
  logic [15:0] info_ff;
  logic [7:0] shift_ff;
  logic [3:0] bitcnt_ff;
  logic second_ff;
  logic go_second_ff;
  logic ten_armed_ff;
  logic [7:0] first_ff;
  logic sda_oe_ff;
  logic scl_oe_ff;
  logic match_evt;
  logic aw_held_ff;
  logic w_held_ff;
  logic [7:0] awaddr_ff;
  logic [7:0] wdata_ff;
  logic wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic do_write;
  logic wr_primary;
  logic wr_ctrl2;
  logic wr_filter;
  logic wr_range;
  logic wr_status;
  logic wr_mask;
  logic wr_known;
  logic byte_done;
  logic accept_now;
  logic ten_read;
  logic [31:0] rd_mux;
  logic rd_known;

  match_if mif ();

  addr_matcher u_matcher
  (
    .m(mif.mat)
  );

  assign mif.gc_enable = ctrl2_ff[i2c_addr_pkg::C2_GEN_CALL];
  assign mif.ten_bit_mode = ctrl2_ff[i2c_addr_pkg::C2_TEN_BIT];
  assign mif.range_enable = ctrl2_ff[i2c_addr_pkg::C2_RANGE_EN];
  assign mif.ad_upper = ctrl2_ff[i2c_addr_pkg::C2_AD_LSB +: 3];
  assign mif.primary = primary_ff[7:1];
  assign mif.range_limit = range_ff[7:1];
  assign mif.rx_byte = shift_ff;

  // pin synchronisers: a level counts once the second and third stages agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
      scl_lvl_ff <= 1'b1;
      sda_lvl_ff <= 1'b1;
    end
    else if (clk_en)
    begin
      scl_sync_ff <= {scl_sync_ff[1:0], scl_i};
      sda_sync_ff <= {sda_sync_ff[1:0], sda_i};
      scl_lvl_ff <= nxt_scl;
      sda_lvl_ff <= nxt_sda;
    end
  end

  assign nxt_scl = (scl_sync_ff[1] == scl_sync_ff[2]) ? scl_sync_ff[2] : scl_lvl_ff;
  assign nxt_sda = (sda_sync_ff[1] == sda_sync_ff[2]) ? sda_sync_ff[2] : sda_lvl_ff;
  assign scl_rise = clk_en && !scl_lvl_ff && nxt_scl;
  assign scl_fall = clk_en && scl_lvl_ff && !nxt_scl;
  // sda moving while scl stays high marks start or stop
  assign start_evt = clk_en && scl_lvl_ff && nxt_scl && sda_lvl_ff && !nxt_sda;
  assign stop_evt = clk_en && scl_lvl_ff && nxt_scl && !sda_lvl_ff && nxt_sda;

  assign byte_done = scl_fall && (bitcnt_ff == 4'h8);
  assign ten_read = mif.hit_hdr10 && shift_ff[0] && ten_armed_ff;
  always_comb
  begin
    accept_now = 1'b0;
    if (second_ff)
    begin
      accept_now = mif.hit_low10;
    end
    else if (mif.ten_bit_mode)
    begin
      accept_now = (mif.hit_hdr10 && !shift_ff[0]) || ten_read || mif.hit_gc;
    end
    else
    begin
      accept_now = mif.hit_primary || mif.hit_range || mif.hit_gc;
    end
  end
  // a ten-bit write header alone is no match yet; the low byte decides
  assign match_evt = byte_done && (state_ff == i2c_addr_pkg::ST_RECV) && accept_now
    && !(!second_ff && mif.ten_bit_mode && mif.hit_hdr10 && !shift_ff[0]);

  // address phase state machine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= i2c_addr_pkg::ST_IDLE;
      shift_ff <= 8'h00;
      bitcnt_ff <= 4'h0;
      second_ff <= 1'b0;
      go_second_ff <= 1'b0;
      ten_armed_ff <= 1'b0;
      first_ff <= 8'h00;
      sda_oe_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      if (stop_evt)
      begin
        state_ff <= i2c_addr_pkg::ST_IDLE;
        ten_armed_ff <= 1'b0;
        sda_oe_ff <= 1'b0;
      end
      else if (start_evt)
      begin
        state_ff <= i2c_addr_pkg::ST_RECV;
        bitcnt_ff <= 4'h0;
        second_ff <= 1'b0;
        sda_oe_ff <= 1'b0;
      end
      else
      begin
        case (state_ff)
          i2c_addr_pkg::ST_RECV:
          begin
            if (scl_rise)
            begin
              // sda taken at the same sync stage as scl: a late ack release still meets the edge
              shift_ff <= {shift_ff[6:0], nxt_sda};
              bitcnt_ff <= bitcnt_ff + 4'h1;
            end
            else if (byte_done)
            begin
              if (!second_ff)
              begin
                first_ff <= shift_ff;
              end
              if (accept_now)
              begin
                state_ff <= i2c_addr_pkg::ST_ACK;
                sda_oe_ff <= 1'b1;
                go_second_ff <= !second_ff && mif.ten_bit_mode && mif.hit_hdr10 && !shift_ff[0];
                if (second_ff)
                begin
                  ten_armed_ff <= 1'b1;
                end
              end
              else
              begin
                state_ff <= i2c_addr_pkg::ST_IGNORE;
              end
            end
          end
          i2c_addr_pkg::ST_ACK:
          begin
            if (scl_fall)
            begin
              sda_oe_ff <= 1'b0;
              bitcnt_ff <= 4'h0;
              if (go_second_ff)
              begin
                state_ff <= i2c_addr_pkg::ST_RECV;
                second_ff <= 1'b1;
              end
              else
              begin
                state_ff <= i2c_addr_pkg::ST_BUSY;
              end
            end
          end
          i2c_addr_pkg::ST_IDLE, i2c_addr_pkg::ST_BUSY, i2c_addr_pkg::ST_IGNORE:
          begin
            state_ff <= state_ff;
          end
          default:
          begin
            state_ff <= i2c_addr_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // hold scl low while the matched slave waits on software, unless running independent
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_oe_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      scl_oe_ff <= (state_ff == i2c_addr_pkg::ST_BUSY) && pend_ff
        && !ctrl2_ff[i2c_addr_pkg::C2_RATE_IND] && !scl_lvl_ff;
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_oe_ff;
  assign sda_oe = sda_oe_ff;

  // axi write side: address and data are caught in either order
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign do_write = clk_en && aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_primary = do_write && wstrb_ff && (awaddr_ff == i2c_addr_pkg::ADR_PRIMARY);
  assign wr_ctrl2 = do_write && wstrb_ff && (awaddr_ff == i2c_addr_pkg::ADR_CTRL2);
  assign wr_filter = do_write && wstrb_ff && (awaddr_ff == i2c_addr_pkg::ADR_FILTER);
  assign wr_range = do_write && wstrb_ff && (awaddr_ff == i2c_addr_pkg::ADR_RANGE);
  assign wr_status = do_write && wstrb_ff && (awaddr_ff == i2c_addr_pkg::ADR_IRQ_STATUS);
  assign wr_mask = do_write && wstrb_ff && (awaddr_ff == i2c_addr_pkg::ADR_IRQ_MASK);
  assign wr_known = (awaddr_ff == i2c_addr_pkg::ADR_PRIMARY) || (awaddr_ff == i2c_addr_pkg::ADR_CTRL2)
    || (awaddr_ff == i2c_addr_pkg::ADR_FILTER) || (awaddr_ff == i2c_addr_pkg::ADR_RANGE)
    || (awaddr_ff == i2c_addr_pkg::ADR_IRQ_STATUS) || (awaddr_ff == i2c_addr_pkg::ADR_IRQ_MASK)
    || (awaddr_ff == i2c_addr_pkg::ADR_MATCH_INFO);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      wstrb_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= i2c_addr_pkg::RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata[7:0];
        wstrb_ff <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_known ? i2c_addr_pkg::RESP_OKAY : i2c_addr_pkg::RESP_SLVERR;
      end
      else if (bvalid_ff && s_axi_bready)
      begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      primary_ff <= i2c_addr_pkg::RESET_BYTE;
      range_ff <= i2c_addr_pkg::RESET_BYTE;
      ctrl2_ff <= i2c_addr_pkg::RESET_BYTE;
      filter_ff <= i2c_addr_pkg::RESET_BYTE;
      mask_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_primary)
      begin
        primary_ff <= {wdata_ff[7:1], 1'b0};
      end
      if (wr_range)
      begin
        range_ff <= {wdata_ff[7:1], 1'b0};
      end
      if (wr_ctrl2)
      begin
        ctrl2_ff <= wdata_ff & i2c_addr_pkg::C2_WRITE_MASK;
      end
      if (wr_filter)
      begin
        filter_ff <= wdata_ff & i2c_addr_pkg::FL_WRITE_MASK;
      end
      if (wr_mask)
      begin
        mask_ff <= wdata_ff[i2c_addr_pkg::IRQ_PEND];
      end
    end
  end

  // sticky flags: a hardware set in the clearing cycle wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stop_seen_ff <= 1'b0;
      start_seen_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      stop_seen_ff <= stop_evt || (stop_seen_ff && !(wr_filter && wdata_ff[i2c_addr_pkg::FL_STOP_SEEN]));
      start_seen_ff <= start_evt || (start_seen_ff && !(wr_filter && wdata_ff[i2c_addr_pkg::FL_START_SEEN]));
    end
  end

  // pending flag re-sets while an enabled stop or start flag is still up
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      pend_ff <= match_evt
        || (filter_ff[i2c_addr_pkg::FL_SS_IRQ_EN] && (stop_seen_ff || start_seen_ff))
        || (pend_ff && !(wr_status && wdata_ff[i2c_addr_pkg::IRQ_PEND]));
      irq_ff <= pend_ff && mask_ff;
    end
  end

  assign irq = irq_ff;

  // last matched address for software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      info_ff <= 16'h0000;
    end
    else if (clk_en && match_evt)
    begin
      info_ff <= 16'h0000;
      info_ff[i2c_addr_pkg::MI_GC] <= mif.hit_gc;
      info_ff[i2c_addr_pkg::MI_RANGE] <= mif.hit_range && !mif.hit_primary;
      info_ff[i2c_addr_pkg::MI_TEN] <= mif.ten_bit_mode && !mif.hit_gc;
      if (second_ff)
      begin
        info_ff[9:0] <= {first_ff[2:1], shift_ff};
      end
      else if (ten_read)
      begin
        info_ff[9:0] <= {shift_ff[2:1], info_ff[7:0]};
      end
      else
      begin
        info_ff[9:0] <= {3'h0, shift_ff[7:1]};
      end
    end
  end

  // axi read side
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_known = 1'b1;
    case ({s_axi_araddr[7:2], 2'h0})
      i2c_addr_pkg::ADR_PRIMARY: rd_mux[7:0] = primary_ff;
      i2c_addr_pkg::ADR_CTRL2: rd_mux[7:0] = ctrl2_ff & i2c_addr_pkg::C2_WRITE_MASK;
      i2c_addr_pkg::ADR_FILTER:
      begin
        rd_mux[7:0] = filter_ff;
        rd_mux[i2c_addr_pkg::FL_STOP_SEEN] = stop_seen_ff;
        rd_mux[i2c_addr_pkg::FL_START_SEEN] = start_seen_ff;
      end
      i2c_addr_pkg::ADR_RANGE: rd_mux[7:0] = range_ff;
      i2c_addr_pkg::ADR_IRQ_STATUS: rd_mux[i2c_addr_pkg::IRQ_PEND] = pend_ff;
      i2c_addr_pkg::ADR_IRQ_MASK: rd_mux[i2c_addr_pkg::IRQ_PEND] = mask_ff;
      i2c_addr_pkg::ADR_MATCH_INFO: rd_mux[15:0] = info_ff;
      default: rd_known = 1'b0;
    endcase
  end

  assign s_axi_arready = !rvalid_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= i2c_addr_pkg::RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (s_axi_arvalid && !rvalid_ff)
      begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_mux;
        rresp_ff <= rd_known ? i2c_addr_pkg::RESP_OKAY : i2c_addr_pkg::RESP_SLVERR;
      end
      else if (rvalid_ff && s_axi_rready)
      begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

endmodule

/* dv/i2c_master_model.sv */
// Purpose: behavioural i2c bus master on the open-drain lines
// Assumes: pull-ups on both lines, 160 ns bit period
// Notes: waits out clock stretching by the slave
`timescale 1ns/10ps
module i2c_master_model
(
  input wire logic scl_oe,
  input wire logic sda_oe,
  output wire logic scl_line,
  output wire logic sda_line
);
  logic scl_drv = 1'b1;
  logic sda_drv = 1'b1;
  // wired-and with pull-up: a released line reads high
  assign scl_line = scl_drv & ~scl_oe;
  assign sda_line = sda_drv & ~sda_oe;

  // the slave may only start holding scl after release, so the line is looked at later
  // the 7 ns realigns to the original phase after a stretch
  task automatic rise();
    scl_drv = 1'b1;
    #20;
    if (!scl_line)
    begin
      wait (scl_line);
      #7;
    end
  endtask

  // offset keeps line edges away from aclk edges
  task automatic start();
    #7;
    sda_drv = 1'b1;
    #40;
    rise();
    #20;
    sda_drv = 1'b0;
    #80;
    scl_drv = 1'b0;
    #40;
  endtask

  task automatic put_bit(input logic b, output logic got);
    sda_drv = b;
    #40;
    rise();
    #20;
    got = sda_line;
    #40;
    scl_drv = 1'b0;
    #40;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic got;
    for (int i = 7; i >= 0; i--)
      put_bit(b[i], got);
    put_bit(1'b1, got);
    ack = ~got;
  endtask

  task automatic stop();
    sda_drv = 1'b0;
    #40;
    rise();
    #20;
    sda_drv = 1'b1;
    #80;
  endtask
endmodule

/* dv/i2c_slave_address_control_assertions.sv */
// Purpose: bus handshake and register checks at the block ports
// Assumes: synchronous active-low reset
// Notes: clk_en low freezes the block, so antecedents that take a transfer require it
`timescale 1ns/10ps
module i2c_slave_address_control_assertions
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sda_oe
);
  logic [5:0] aw_idx_ff;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      aw_idx_ff <= 6'h00;
    else if (clk_en && s_axi_awvalid && s_axi_awready)
      aw_idx_ff <= s_axi_awaddr[7:2];
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence both_taken;
    clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    clk_en && s_axi_arvalid && s_axi_arready;
  endsequence
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready high during response");
  write_answer_a: assert property (both_taken ##1 clk_en |=> s_axi_bvalid)
    else $error("write response late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  write_slverr_a: assert property ($rose(s_axi_bvalid) && aw_idx_ff > 6'h0A |-> s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");
  read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  read_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read ready wrong");
  ctrl2_reserved_a: assert property (rd_taken ##0 s_axi_araddr == 8'h14 |=> s_axi_rdata[5] == 1'b0)
    else $error("reserved bit reads one");
  read_slverr_a: assert property (rd_taken ##0 s_axi_araddr[7:2] > 6'h0A |=> s_axi_rresp == 2'h2 && s_axi_rdata == 0)
    else $error("unmapped read not refused");
  ack_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*4])
    else $error("acknowledge too short");
endmodule
bind i2c_slave_address_control i2c_slave_address_control_assertions chk_i (.aclk, .aresetn, .clk_en,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .sda_oe);

/* dv/i2c_slave_address_control_bench.sv */
// Purpose: register and bus-address tests of the slave address block
// Assumes: i2c master model on the far side
// Notes: rate independence kept set outside the stretch test so the master never stalls
`timescale 1ns/10ps
module i2c_slave_address_control_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, a, mask_v;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic scl_line, sda_line, scl_oe, sda_oe;
  int fail_count, total_checks, cycles;
  // {ack expected, control two, header or 0, address byte}
  logic [24:0] tbl [13] = '{25'h1100050,
    25'h0100054, 25'h1180054, 25'h1180058, 25'h018005A, 25'h018004E,
    25'h0100000, 25'h1900001,
    25'h0500050, 25'h155F4A8,
    25'h055F6A8, 25'h055F428, 25'h1150050};

  i2c_slave_address_control uut (.aclk, .aresetn, .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_i(scl_line), .scl_o(), .scl_oe,
    .sda_i(sda_line), .sda_o(), .sda_oe, .irq);
  i2c_master_model m (.scl_oe, .sda_oe, .scl_line, .sda_line);

  task automatic stop_test();
    if (fail_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic axi_wr(input logic [7:0] ad, input logic [7:0] dat, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= {24'h000000, dat};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask

  task automatic axi_rd(input logic [7:0] ad);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
    axi_rd(ad);
    chk("rdata", exp, d);
    chk("rresp", 2'h0, r);
  endtask

  task automatic try_addr(input logic [15:0] b, input logic exp);
    logic ack_hdr, ack_low;
    ack_hdr = 1'b1;
    m.start();
    if (b[15:8] != 8'h00)
      m.send_byte(b[15:8], ack_hdr);
    m.send_byte(b[7:0], ack_low);
    m.stop();
    chk("ack", exp, ack_hdr & ack_low);
    rdc(8'h20, exp);
    chk("irq", exp & mask_v, irq);
    rdc(8'h18, 32'h50);
    axi_wr(8'h18, 8'h50, 2'h0);
    axi_wr(8'h20, 8'h01, 2'h0);
  endtask

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      fail_count++;
      stop_test();
    end
  end

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(8'h14, 32'h0);
    rdc(8'h18, 32'h0);
    axi_wr(8'h14, 8'hFF, 2'h0);
    rdc(8'h14, 32'hDF);
    axi_wr(8'h3C, 8'hFF, 2'h2);
    axi_rd(8'h3C);
    chk("unmapped rresp", 2'h2, r);
    chk("unmapped rdata", 32'h0, d);
    axi_wr(8'h08, 8'h50, 2'h0);
    axi_wr(8'h1C, 8'h58, 2'h0);
    axi_wr(8'h24, 8'h01, 2'h0);
    mask_v = 1'b1;
    foreach (tbl[i])
    begin
      axi_wr(8'h14, tbl[i][23:16], 2'h0);
      try_addr(tbl[i][15:0], tbl[i][24]);
    end
    axi_wr(8'h20, 8'h01, 2'h0);
    axi_wr(8'h14, 8'h10, 2'h0);
    axi_wr(8'h24, 8'h00, 2'h0);
    mask_v = 1'b0;
    try_addr(16'h0050, 1'b1);
    axi_wr(8'h24, 8'h01, 2'h0);
    axi_wr(8'h18, 8'h20, 2'h0);
    m.start();
    m.stop();
    rdc(8'h20, 32'h1);
    chk("irq", 1'b1, irq);
    axi_wr(8'h18, 8'h70, 2'h0);
    axi_wr(8'h20, 8'h01, 2'h0);
    rdc(8'h20, 32'h0);
    rdc(8'h18, 32'h20);
    axi_wr(8'h18, 8'h00, 2'h0);
    axi_wr(8'h14, 8'h00, 2'h0);
    fork
      begin
        m.start();
        m.send_byte(8'h50, a);
        m.stop();
      end
      begin
        wait (sda_oe === 1'b1);
        repeat (24) @(posedge aclk);
        chk("scl_oe", 1'b1, scl_oe);
        axi_wr(8'h20, 8'h01, 2'h0);
      end
    join
    chk("ack", 1'b1, a);
    stop_test();
  end
endmodule
